// [dv/msb_motor_model.sv]
`timescale 1ns/1ps
// power stage and motor: speed follows the drive state
module msb_motor_model #(
  parameter TOP = 12'h190
) (
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_slow,
  input  wire        i_output_enable,
  input  wire        i_ramp_down,
  input  wire        i_dc_inject,
  output reg  [11:0] o_output_freq
);
  wire [11:0] step = i_slow ? 12'h001 : 12'h004;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_output_freq <= 12'h000;
    end else if (i_dc_inject || i_ramp_down || !i_output_enable) begin
      o_output_freq <= (o_output_freq > step) ? o_output_freq - step : 12'h000;
    end else if (o_output_freq < TOP) begin
      o_output_freq <= o_output_freq + step;
    end
  end
endmodule // msb_motor_model

// [dv/msb_stop_seq_monitor.sv]
`timescale 1ns/1ps
// port checker for the stop sequencer
module msb_stop_seq_monitor (
  input wire        i_sys_clk,
  input wire        i_rstn,
  input wire        i_run,
  input wire        i_cfg_load,
  input wire        i_mf_input,
  input wire [7:0]  i_mf_function,
  input wire [4:0]  i_analog_function,
  input wire [11:0] i_analog_level,
  input wire [15:0] i_fast_stop_ramp_time,
  input wire [15:0] i_decel_time_primary,
  input wire        o_output_enable,
  input wire        o_ramp_down,
  input wire [15:0] o_ramp_time,
  input wire        o_dc_inject,
  input wire [6:0]  o_inject_current,
  input wire        o_run_lockout,
  input wire        o_fast_stop_active
);
  default clocking mon_cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // fast stop time as captured by a settings load
  reg [15:0] fst_cfg_reg;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fst_cfg_reg <= 16'h0064;
    end else if (i_cfg_load) begin
      fst_cfg_reg <= (i_fast_stop_ramp_time > 16'hea60) ? 16'hea60 : i_fast_stop_ramp_time;
    end
  end
  ////////////////////////////////////////////////////////////
  // drive fully idle: run, output, lockout, ramp down and injection all off
  sequence s_idle_request;
    !i_run && !o_output_enable && !o_run_lockout && !o_ramp_down && !o_dc_inject;
  endsequence
  // injection held by the digital input while stopped
  sequence s_idle_inject;
    o_dc_inject && !o_ramp_down && !o_run_lockout && i_mf_input && (i_mf_function == 8'h3c);
  endsequence
  // analog level steady over four samples (three $stable checks in a row)
  sequence s_level_steady;
    $stable(i_analog_level) [*3];
  endsequence
  ////////////////////////////////////////////////////////////
  coast_output_off_a: assert property (
    o_run_lockout && !o_fast_stop_active |-> !o_output_enable)
    else $error("output on during coast lockout");
  idle_input_inject_a: assert property (
    s_idle_request ##0 ($rose(i_mf_input) && i_mf_function == 8'h3c) |-> ##[1:4] o_dc_inject)
    else $error("input injection not applied");
  run_ends_inject_a: assert property (
    s_idle_inject ##0 $rose(i_run) |-> ##[1:5] !o_dc_inject)
    else $error("run did not end input injection");
  inject_pct_range_a: assert property (
    o_dc_inject |-> o_inject_current <= 7'h64)
    else $error("injection current above full scale");
  decel_ramp_time_a: assert property (
    o_ramp_down && !o_fast_stop_active |-> o_ramp_time == i_decel_time_primary)
    else $error("normal stop not using decel time");
  fast_ramp_time_a: assert property (
    o_fast_stop_active && o_ramp_down |-> o_ramp_time == fst_cfg_reg)
    else $error("fast stop not using fast time");
  fast_stop_lockout_a: assert property (
    o_fast_stop_active |-> o_run_lockout)
    else $error("restart open during fast stop");
  analog_scale_a: assert property (
    s_level_steady ##0 (o_dc_inject && $past(o_dc_inject) && i_analog_function == 5'h06)
    |-> {12'h000, o_inject_current} == ({7'h00, i_analog_level} * 19'h00064) >> 12)
    else $error("analog injection current mis-scaled");
endmodule // msb_stop_seq_monitor

bind msb_stop_seq msb_stop_seq_monitor msb_stop_seq_monitor_inst (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_run(i_run), .i_mf_input(i_mf_input),
  .i_cfg_load(i_cfg_load),
  .i_mf_function(i_mf_function), .i_analog_function(i_analog_function),
  .i_analog_level(i_analog_level), .i_fast_stop_ramp_time(i_fast_stop_ramp_time),
  .i_decel_time_primary(i_decel_time_primary), .o_output_enable(o_output_enable),
  .o_ramp_down(o_ramp_down), .o_ramp_time(o_ramp_time), .o_dc_inject(o_dc_inject),
  .o_inject_current(o_inject_current), .o_run_lockout(o_run_lockout),
  .o_fast_stop_active(o_fast_stop_active)
);

// [dv/msb_stop_seq_tb_top.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
// stop sequencer bench, motor model on the far side
module msb_stop_seq_tb_top;
  typedef struct {int s; logic [15:0] v;} msb_note_t;
  reg         clk = 1'b0;
  reg         rstn, run, jog, mf_in, cfg_ld, slow;
  reg  [7:0]  mf_fn;
  reg  [4:0]  ana_fn;
  reg  [11:0] ana_lvl, fref;
  reg  [1:0]  stop_sel, ctrl, below;
  reg  [6:0]  pct, no_load;
  reg  [9:0]  start_t, stop_t, off_t;
  reg  [15:0] decel, fst;
  reg  [31:0] seed = 32'h5518;
  wire [11:0] freq, ref_eff;
  wire [15:0] rtime;
  wire [6:0]  icur;
  wire        en, rdn, dci, zs, lko, fsa;
  wire [15:0] outs [0:8];
  int         errors = 0;
  int         check_count = 0;
  msb_note_t  notes[$];
  msb_note_t  note;
  string      nm [0:8] = '{"enable", "ramp_down", "ramp_time", "dc_inject", "current",
                           "ref_eff", "lockout", "fast_stop", "zero_speed"};
  ////////////////////////////////////////////////////////////
  msb_stop_seq #(.TICK_CYCLES(4)) msb_stop_seq_inst (
    .i_sys_clk(clk), .i_rstn(rstn), .i_run(run), .i_jog(jog), .i_mf_input(mf_in),
    .i_mf_function(mf_fn), .i_analog_function(ana_fn), .i_analog_level(ana_lvl),
    .i_cfg_load(cfg_ld), .i_stop_method_select(stop_sel), .i_control_method_select(ctrl),
    .i_below_min_freq_behaviour(below), .i_brake_start_freq(7'h05),
    .i_brake_current_pct(pct), .i_start_brake_time(start_t), .i_stop_brake_time(stop_t),
    .i_fast_stop_ramp_time(fst), .i_ramp_time_unit_select(1'b1),
    .i_decel_time_primary(decel), .i_min_output_freq(12'h00f), .i_max_output_freq(12'h258),
    .i_motor_no_load_current(no_load), .i_min_output_off_time(off_t), .i_output_freq(freq),
    .i_freq_ref(fref), .o_output_enable(en), .o_ramp_down(rdn), .o_ramp_time(rtime),
    .o_dc_inject(dci), .o_inject_current(icur), .o_zero_speed(zs), .o_freq_ref_eff(ref_eff),
    .o_run_lockout(lko), .o_fast_stop_active(fsa));
  msb_motor_model msb_motor_model_inst (
    .i_sys_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_output_enable(en),
    .i_ramp_down(rdn), .i_dc_inject(dci), .o_output_freq(freq));
  // observed outputs by index
  assign outs[0] = {15'h0000, en};
  assign outs[1] = {15'h0000, rdn};
  assign outs[2] = rtime;
  assign outs[3] = {15'h0000, dci};
  assign outs[4] = {9'h000, icur};
  assign outs[5] = {4'h0, ref_eff};
  assign outs[6] = {15'h0000, lko};
  assign outs[7] = {15'h0000, fsa};
  assign outs[8] = {15'h0000, zs};
  always #5 clk = ~clk;
  // every queued note, oldest first, against the settled outputs
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      note = notes.pop_front();
      `CHK(nm[note.s], note.v, outs[note.s])
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input int s, input logic [15:0] v);
    notes.push_back('{s, v});
  endtask
  // bounded wait, then note the value awaited
  task automatic wt(input int s, input logic [15:0] v, input int n);
    int k;
    k = 0;
    while (outs[s] !== v && k < n) begin
      @(posedge clk);
      k++;
    end
    chk(s, v);
  endtask
  task automatic idle();
    wt(0, 0, 3000);
    wt(1, 0, 3000);
    wt(3, 0, 3000);
    wt(6, 0, 6000);
    cyc(4);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #900000;
    errors++;
    results();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {rstn, run, jog, mf_in, cfg_ld, slow} <= 6'h00;
    {mf_fn, ana_fn, ana_lvl, fref} <= {8'h3c, 5'h00, 12'h000, 12'h190};
    {stop_sel, ctrl, below, pct, no_load} <= {6'h00, 7'h14, 7'h1e};
    {start_t, stop_t, off_t, decel} <= {10'h000, 10'h00a, 10'h008, 16'h000a};
    fst <= 16'h0032;
    cyc(8);
    rstn <= 1'b1;
    cyc(2);
    chk(0, 0);
    mf_in <= 1'b1;
    wt(3, 1, 8);
    chk(4, 16'h0032);
    run <= 1'b1;
    wt(3, 0, 6);
    mf_in <= 1'b0;
    cyc(60);
    run <= 1'b0;
    idle();
    $display("test defaults done");
    pct <= 7'(rnd() % 101);
    decel <= 16'(rnd() % 20 + 10);
    stop_t <= 10'(rnd() % 20 + 1);
    off_t <= 10'(rnd() % 8 + 4);
    fst <= 16'(rnd() % 500 + 1);
    fref <= 12'(rnd() % 400 + 20);
    cfg_ld <= 1'b1;
    cyc(1);
    cfg_ld <= 1'b0;
    run <= 1'b1;
    wt(0, 1, 8);
    chk(3, 0);
    cyc(120);
    run <= 1'b0;
    wt(1, 1, 8);
    chk(2, decel);
    wt(3, 1, 3000);
    chk(4, {9'h000, pct});
    idle();
    $display("test ramp stop done");
    for (int m = 1; m < 4; m++) begin
      stop_sel <= 2'(m);
      slow <= m[0];
      run <= 1'b1;
      wt(0, 1, 8);
      cyc(150);
      run <= 1'b0;
      wt(0, 0, 8);
      if (m == 2) begin
        chk(3, 0);
        wt(3, 1, 300);
        chk(4, {9'h000, pct});
      end else begin
        wt(6, 1, 4);
        run <= 1'b1;
        cyc(6);
        chk(0, 0);
        run <= 1'b0;
      end
      idle();
    end
    $display("test stop methods done");
    for (int c = 0; c < 2; c++) begin
      mf_fn <= c[0] ? 8'h11 : 8'h0f;
      mf_in <= c[0];
      cyc(4);
      run <= 1'b1;
      wt(0, 1, 8);
      cyc(60);
      mf_in <= ~c[0];
      wt(7, 1, 8);
      chk(6, 1);
      wt(1, 1, 4);
      chk(2, fst);
      cyc(30);
      run <= 1'b0;
      mf_in <= c[0];
      idle();
      wt(7, 0, 8);
    end
    mf_in <= 1'b0;
    cyc(4);
    $display("test fast stop done");
    {mf_fn, ana_fn, ana_lvl} <= {8'h3c, 5'h06, 12'(rnd())};
    cyc(1);
    mf_in <= 1'b1;
    wt(3, 1, 8);
    cyc(4);
    chk(4, 16'((ana_lvl * 19'h00064) >> 12));
    jog <= 1'b1;
    wt(3, 0, 6);
    {mf_in, jog, ana_fn} <= 7'h00;
    idle();
    $display("test analog done");
    {ctrl, below, start_t, fref} <= {2'h3, 2'h3, 10'h005, 12'h00a};
    stop_sel <= 2'h0;
    cfg_ld <= 1'b1;
    cyc(1);
    cfg_ld <= 1'b0;
    run <= 1'b1;
    wt(3, 1, 8);
    chk(4, {9'h000, no_load});
    wt(0, 1, 60);
    chk(5, 0);
    cyc(100);
    run <= 1'b0;
    wt(8, 1, 3000);
    cyc(4);
    $display("test flux done");
    results();
  end
endmodule // msb_stop_seq_tb_top

// [hdl/msb_stop_seq.v]
`timescale 1ns/1ps
`include "msb_regs.vh"
// Behaviour
// R1: method 0 ramps down with decel time
// R2: below brake freq, DC inject stop time
// R3: flux vector standstill follows below-min setting
// R4: flux vector zero-speed at brake freq
// R5: flux vector start current is no-load current
// R6: method 1 cuts output at once
// R7: coast ignores run until off time
// R8: method 2 waits off time then injects
// R9: method 3 shuts output, motor coasts
// R10: timed coast locks out run for interval
// R11: start brake time zero disables start injection
// R12: start brake time 0.01 s, max 10 s
// R13: brake current pct 0..100, default 50
// R14: input code 60 injects while stopped
// R15: run or jog ends input injection
// R16: analog code 6 scales brake current
// R17: code 15/17 fast stop uses fast time
// R18: code 15 closes active, 17 opens
// R19: no restart until fast stop done
// R20: operator clears run and stop input
// R21: fast stop time 0..6000 s, default 10
// R22: unit select 0 gives 0.01 s ramps
// R23: DC stop time = t*10*f/fmax
// R24: brake freq 0..10 Hz, floor min freq
// R25: stop brake time 0.01 s, default 0.5
// R26: below-min 3 forces reference to zero
// R27: lockout = decel*f/fmax
// R28: stop method latched at run withdrawal
module msb_stop_seq #(
  parameter TICK_CYCLES = `MSB_TICK_CYCLES
) (
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_run,
  input  wire        i_jog,
  input  wire        i_mf_input,
  input  wire [7:0]  i_mf_function,
  input  wire [4:0]  i_analog_function,
  input  wire [11:0] i_analog_level,
  input  wire        i_cfg_load,
  input  wire [1:0]  i_stop_method_select,
  input  wire [1:0]  i_control_method_select,
  input  wire [1:0]  i_below_min_freq_behaviour,
  input  wire [6:0]  i_brake_start_freq,
  input  wire [6:0]  i_brake_current_pct,
  input  wire [9:0]  i_start_brake_time,
  input  wire [9:0]  i_stop_brake_time,
  input  wire [15:0] i_fast_stop_ramp_time,
  input  wire        i_ramp_time_unit_select,
  input  wire [15:0] i_decel_time_primary,
  input  wire [11:0] i_min_output_freq,
  input  wire [11:0] i_max_output_freq,
  input  wire [6:0]  i_motor_no_load_current,
  input  wire [9:0]  i_min_output_off_time,
  input  wire [11:0] i_output_freq,
  input  wire [11:0] i_freq_ref,
  output reg         o_output_enable,
  output reg         o_ramp_down,
  output reg  [15:0] o_ramp_time,
  output reg         o_dc_inject,
  output reg  [6:0]  o_inject_current,
  output reg         o_zero_speed,
  output reg  [11:0] o_freq_ref_eff,
  output reg         o_run_lockout,
  output reg         o_fast_stop_active
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_RUN   = 3'h2;
  localparam ST_DECEL = 3'h3;
  localparam ST_WAIT  = 3'h4;
  localparam ST_INJ   = 3'h5;
  localparam ST_HOLD  = 3'h6;

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  reg [1:0] run_s_reg, jog_s_reg, mf_s_reg;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_s_reg <= 2'h0;
      jog_s_reg <= 2'h0;
      mf_s_reg  <= 2'h0;
    end else begin
      run_s_reg <= {run_s_reg[0], i_run};
      jog_s_reg <= {jog_s_reg[0], i_jog};
      mf_s_reg  <= {mf_s_reg[0], i_mf_input};
    end
  end
  wire run = run_s_reg[1];
  wire jog = jog_s_reg[1];
  wire go  = run | jog;

  //////////////////////////////////////////////////////////////////////////
  // settings with reset defaults, clamped on load
  reg [9:0]  start_time_reg, stop_time_reg;
  reg [6:0]  brake_freq_reg, brake_pct_reg;
  reg [15:0] fstop_time_reg;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_time_reg <= `MSB_RST_START_BRAKE;
      stop_time_reg  <= `MSB_RST_STOP_BRAKE;
      brake_freq_reg <= `MSB_RST_BRAKE_FREQ;
      brake_pct_reg  <= `MSB_RST_BRAKE_PCT;
      fstop_time_reg <= `MSB_RST_FSTOP_TIME;
    end else if (i_cfg_load) begin
      // R12: start time clamp
      start_time_reg <= (i_start_brake_time > `MSB_MAX_BRAKE_TIME) ?
                        `MSB_MAX_BRAKE_TIME : i_start_brake_time;
      // R25: stop time clamp
      stop_time_reg  <= (i_stop_brake_time > `MSB_MAX_BRAKE_TIME) ?
                        `MSB_MAX_BRAKE_TIME : i_stop_brake_time;
      // R24: brake freq clamp
      brake_freq_reg <= (i_brake_start_freq > `MSB_MAX_BRAKE_FREQ) ?
                        `MSB_MAX_BRAKE_FREQ : i_brake_start_freq;
      // R13: pct clamp
      brake_pct_reg  <= (i_brake_current_pct > `MSB_MAX_PCT) ?
                        `MSB_MAX_PCT : i_brake_current_pct;
      // R21: fast stop time clamp
      fstop_time_reg <= (i_fast_stop_ramp_time > `MSB_MAX_RAMP_COARSE) ?
                        `MSB_MAX_RAMP_COARSE : i_fast_stop_ramp_time;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // 10 ms tick divider
  reg [31:0] div_reg;
  wire       tick = (div_reg == TICK_CYCLES - 1);
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= tick ? 32'h0 : div_reg + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // derived terms
  wire flux = (i_control_method_select == `MSB_CTRL_FLUX_VECTOR);
  // R18: contact polarity
  wire fstop_in = ((i_mf_function == `MSB_FUNC_FSTOP_NO) & mf_s_reg[1]) |
                  ((i_mf_function == `MSB_FUNC_FSTOP_NC) & ~mf_s_reg[1]);
  // R14: dc inject command input
  wire dcin = (i_mf_function == `MSB_FUNC_DC_INJECT) & mf_s_reg[1];
  // R24: floor at min freq, except flux vector (R4)
  wire [11:0] bf_ext = {5'h0, brake_freq_reg};
  wire [11:0] brake_thr = (!flux && bf_ext < i_min_output_freq) ?
                          i_min_output_freq : bf_ext;
  // R16: analog scaling to pct
  wire [19:0] ana_prod = {8'h0, i_analog_level} * 20'd100;
  wire [6:0]  ana_pct  = ana_prod[18:12];
  wire [6:0]  stop_pct = (i_analog_function == `MSB_FUNC_ANA_BRAKE) ?
                         ana_pct : brake_pct_reg;
  // R5: start current in flux vector
  wire [6:0] start_pct = flux ? i_motor_no_load_current : stop_pct;
  // R22: fine units scaled down to 0.1 s
  wire [15:0] decel_t = i_ramp_time_unit_select ? i_decel_time_primary :
                        i_decel_time_primary / 16'd10;
  wire [11:0] fmax = (i_max_output_freq == 12'h0) ? 12'h1 : i_max_output_freq;
  // R23: dc stop time in ticks
  wire [31:0] dc_prod = {22'h0, stop_time_reg} * 32'd10 * {20'h0, i_output_freq};
  wire [31:0] dc_len  = dc_prod / {20'h0, fmax};
  // R27: lockout in 0.1 s -> ticks x10
  wire [31:0] lo_prod = {16'h0, decel_t} * 32'd10 * {20'h0, i_output_freq};
  wire [31:0] lo_len  = lo_prod / {20'h0, fmax};

  //////////////////////////////////////////////////////////////////////////
  // timers
  reg        t_load, l_load;
  reg [23:0] t_val, l_val;
  wire       t_busy, l_busy;
  msb_tick_timer #(.W(24)) u_seq_timer (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_tick    (tick),
    .i_load    (t_load),
    .i_value   (t_val),
    .o_busy    (t_busy)
  );
  msb_tick_timer #(.W(24)) u_lock_timer (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_tick    (tick),
    .i_load    (l_load),
    .i_value   (l_val),
    .o_busy    (l_busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  reg [2:0] state_reg, state_next;
  reg [1:0] method_reg, method_next;
  reg       fstop_reg, fstop_next;
  reg       stop_inj_reg, stop_inj_next;
  always @* begin
    state_next    = state_reg;
    method_next   = method_reg;
    fstop_next    = fstop_reg;
    stop_inj_next = stop_inj_reg;
    t_load = 1'b0;
    t_val  = 24'h0;
    l_load = 1'b0;
    l_val  = 24'h0;
    case (state_reg)
      ST_IDLE: begin
        // R19: R20: hold fast stop until run and input withdrawn
        if (fstop_reg && !run && !fstop_in) begin
          fstop_next = 1'b0;
        end
        // R7: R10: R19: restart refused while locked
        if (go && !l_busy && !fstop_reg) begin
          // R11: zero start time skips injection
          if (start_time_reg != 10'h0) begin
            t_load     = 1'b1;
            t_val      = {14'h0, start_time_reg};
            state_next = ST_START;
          end else begin
            state_next = ST_RUN;
          end
        end
      end
      ST_START: begin
        if (!go) begin
          state_next = ST_IDLE;
        end else if (!t_busy) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // R17: fast stop ramp
        if (fstop_in) begin
          fstop_next  = 1'b1;
          method_next = `MSB_STOP_RAMP;
          state_next  = ST_DECEL;
        end else if (!go) begin
          // R28: latch method
          method_next = i_stop_method_select;
          case (i_stop_method_select)
            // R1: ramp down
            `MSB_STOP_RAMP: state_next = ST_DECEL;
            // R6: R7: coast, lock for off time
            `MSB_STOP_COAST: begin
              l_load     = 1'b1;
              l_val      = {14'h0, i_min_output_off_time};
              state_next = ST_IDLE;
            end
            // R8: wait off time first
            `MSB_STOP_DCBRAKE: begin
              t_load     = 1'b1;
              t_val      = {14'h0, i_min_output_off_time};
              state_next = ST_WAIT;
            end
            // R9: R10: R27: timed coast
            `MSB_STOP_COAST_TIMER: begin
              l_load     = 1'b1;
              l_val      = lo_len[23:0];
              state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_DECEL: begin
        if (go && !fstop_reg) begin
          state_next = ST_RUN;
        // R2: R4: below brake freq
        end else if (i_output_freq <= brake_thr) begin
          t_load     = 1'b1;
          t_val      = {14'h0, stop_time_reg};
          state_next = ST_INJ;
        end
      end
      ST_WAIT: begin
        if (!t_busy) begin
          // R8: R23: injection length
          t_load     = 1'b1;
          t_val      = dc_len[23:0];
          state_next = ST_INJ;
        end
      end
      ST_INJ: begin
        if (!t_busy) begin
          // R3: flux vector with zero-speed hold
          if (flux && i_below_min_freq_behaviour == `MSB_BELOW_MIN_ZERO &&
              !fstop_reg) begin
            state_next = ST_HOLD;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (go) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // R14: R15: injection on input while stopped
    stop_inj_next = (state_next == ST_IDLE) & dcin & ~go;
  end

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg    <= ST_IDLE;
      method_reg   <= `MSB_STOP_RAMP;
      fstop_reg    <= 1'b0;
      stop_inj_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      method_reg   <= method_next;
      fstop_reg    <= fstop_next;
      stop_inj_reg <= stop_inj_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_output_enable    <= 1'b0;
      o_ramp_down        <= 1'b0;
      o_ramp_time        <= 16'h0;
      o_dc_inject        <= 1'b0;
      o_inject_current   <= 7'h0;
      o_zero_speed       <= 1'b0;
      o_freq_ref_eff     <= 12'h0;
      o_run_lockout      <= 1'b0;
      o_fast_stop_active <= 1'b0;
    end else begin
      o_output_enable  <= (state_next != ST_IDLE && state_next != ST_WAIT) |
                          stop_inj_next;
      o_ramp_down      <= (state_next == ST_DECEL);
      // R17: R21: fast stop time replaces decel time
      o_ramp_time      <= fstop_next ? fstop_time_reg : i_decel_time_primary;
      o_dc_inject      <= (state_next == ST_START) | (state_next == ST_INJ) |
                          stop_inj_next;
      o_inject_current <= (state_next == ST_START) ? start_pct : stop_pct;
      // R4: zero-speed from brake freq in flux vector
      o_zero_speed     <= flux & ((state_next == ST_INJ && method_next ==
                          `MSB_STOP_RAMP) | (state_next == ST_HOLD));
      // R26: zero reference below min
      o_freq_ref_eff   <= (flux && i_below_min_freq_behaviour == `MSB_BELOW_MIN_ZERO
                          && i_freq_ref < i_min_output_freq) ? 12'h0 : i_freq_ref;
      o_run_lockout    <= l_busy | l_load | fstop_next;
      o_fast_stop_active <= fstop_next;
    end
  end
endmodule // msb_stop_seq

// [hdl/msb_tick_timer.v]
`timescale 1ns/1ps
// down counter of 0.01 s ticks, loaded by a pulse
module msb_tick_timer #(
  parameter W = 24
) (
  input  wire         i_sys_clk,
  input  wire         i_rstn,
  input  wire         i_tick,
  input  wire         i_load,
  input  wire [W-1:0] i_value,
  output wire         o_busy
);
  reg [W-1:0] cnt_reg;

  // load wins over counting
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= {W{1'b0}};
    end else if (i_load) begin
      cnt_reg <= i_value;
    end else if (i_tick && cnt_reg != {W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_busy = (cnt_reg != {W{1'b0}});
endmodule // msb_tick_timer

// [include/msb_regs.vh]
`ifndef MSB_REGS_VH
`define MSB_REGS_VH
// stop method codes
`define MSB_STOP_RAMP        2'h0
`define MSB_STOP_COAST       2'h1
`define MSB_STOP_DCBRAKE     2'h2
`define MSB_STOP_COAST_TIMER 2'h3
// control method and below-min behaviour codes
`define MSB_CTRL_FLUX_VECTOR 2'h3
`define MSB_BELOW_MIN_ZERO   2'h3
// input function codes
`define MSB_FUNC_DC_INJECT   8'h3c
`define MSB_FUNC_FSTOP_NO    8'h0f
`define MSB_FUNC_FSTOP_NC    8'h11
`define MSB_FUNC_ANA_BRAKE   5'h06
// reset values (brake time in 0.01 s, fast stop time in 0.1 s, freq in 0.1 Hz, pct)
`define MSB_RST_START_BRAKE  10'h000
`define MSB_RST_STOP_BRAKE   10'h032
`define MSB_RST_BRAKE_FREQ   7'h05
`define MSB_RST_BRAKE_PCT    7'h32
`define MSB_RST_FSTOP_TIME   16'h0064
// limits
`define MSB_MAX_BRAKE_TIME   10'h3e8
`define MSB_MAX_BRAKE_FREQ   7'h64
`define MSB_MAX_PCT          7'h64
`define MSB_MAX_RAMP_FINE    16'hea60
`define MSB_MAX_RAMP_COARSE  16'hea60
// timing: one tick = 10 ms at 100 MHz
`define MSB_TICK_MS          10
`define MSB_CLK_MHZ          100
`define MSB_TICK_CYCLES      (`MSB_TICK_MS * 1000 * `MSB_CLK_MHZ)
// analog full scale code (10 V / 20 mA)
`define MSB_ANA_FULL         12'hfff
`endif
